// >>> include/rpeasd_pkg.sv
/*
  shared constants and fixed-point helpers for the pulse codec and synthesis chain.
  assumes 16-bit two's complement samples with 2^15 scaling throughout.
*/
package rpeasd_pkg;
  localparam int SAMPLE_W = 16;
  localparam int PULSE_NUM = 13;
  localparam int LAR_NUM = 8;
  localparam int SUB_LEN = 40;
  localparam int SUB_NUM = 4;
  localparam int GRID_STEP = 3;
  localparam int HIST_DEPTH = 128;
  localparam int FIFO_DEPTH = 8;
  // parameter words per subsegment: lag, gain, grid, block max, then the pulses
  localparam int PAR_WORDS = 17;
  localparam int PAR_PULSE0 = 4;
  localparam int INTERP_END0 = 13;
  localparam int INTERP_END1 = 27;
  localparam logic signed [31:0] SAT_HI = 32'sh00007FFF;
  localparam logic signed [31:0] SAT_LO = 32'shFFFF8000;
  localparam logic signed [31:0] ROUND_HALF = 32'sh00004000;
  localparam int Q_SHIFT = 15;
  localparam logic signed [15:0] STATE_RST = 16'sh0000;
  localparam logic signed [15:0] QUANT_STEP = 16'sh2000;
  localparam logic signed [15:0] QUANT_LOW = 16'sh9000;
  // 2^15 / step width, as a shift, and the code whose interval starts at zero
  localparam int QUANT_SHIFT = 2;
  localparam int QUANT_MID = 4;
  localparam logic [15:0] BMAX_SMALL_W = 16'h0020;
  localparam logic [15:0] BMAX_GROUP_BASE = 16'h0100;
  localparam logic signed [15:0] GAIN_LEVEL [4] = '{16'sh0CCD, 16'sh2CCD, 16'sh5333, 16'sh7FFF};
  localparam logic signed [15:0] BETA = 16'sh6E14;
  localparam logic [5:0] LAR_OFFSET [8] = '{6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20, 6'h20};
  localparam logic signed [15:0] LAR_STEP [8] = '{16'sh0200, 16'sh0200, 16'sh0200, 16'sh0200,
                                                  16'sh0200, 16'sh0200, 16'sh0200, 16'sh0200};
  localparam logic signed [15:0] RC_KNEE = 16'sh4000;

  function automatic logic signed [15:0] sat16(input logic signed [31:0] x);
    if (x > SAT_HI) return SAT_HI[15:0];
    else if (x < SAT_LO) return SAT_LO[15:0];
    else return x[15:0];
  endfunction

  function automatic logic signed [15:0] add_sat(input logic signed [15:0] a, input logic signed [15:0] b);
    return sat16(32'(a) + 32'(b));
  endfunction

  function automatic logic signed [15:0] sub_sat(input logic signed [15:0] a, input logic signed [15:0] b);
    return sat16(32'(a) - 32'(b));
  endfunction

  // rounded q15 product
  function automatic logic signed [15:0] mult_r(input logic signed [15:0] a, input logic signed [15:0] b);
    logic signed [31:0] p;
    p = 32'(a) * 32'(b) + ROUND_HALF;
    return sat16(p >>> Q_SHIFT);
  endfunction

  function automatic logic [14:0] abs15(input logic signed [15:0] x);
    logic signed [31:0] a;
    a = (x < 0) ? -32'(x) : 32'(x);
    return 15'(sat16(a));
  endfunction

  function automatic logic [5:0] bmax_encode(input logic [14:0] m);
    logic [5:0] c;
    c = 6'(m >> 5);
    for (int g = 1; g <= 7; g++) begin
      if (m >= (15'd1 << (g + 7))) c = 6'(g * 8) + 6'((m >> (g + 4)) & 15'd7);
    end
    return c;
  endfunction

  // decoded maximum is the upper bound of the code's interval
  function automatic logic [14:0] bmax_decode(input logic [5:0] c);
    logic [2:0] s;
    logic [15:0] w;
    logic [15:0] lo;
    s = (c[5:3] == 3'h0) ? 3'h0 : c[5:3] - 3'h1;
    w = BMAX_SMALL_W << s;
    lo = (c[5:3] == 3'h0) ? 16'(c[2:0] * w) : 16'((BMAX_GROUP_BASE << s) + c[2:0] * w);
    return 15'(lo + w - 16'h0001);
  endfunction

  // count of decision thresholds passed by x / bmax, compared without a divider
  function automatic logic [2:0] quant_code(input logic signed [15:0] x, input logic [14:0] bmax);
    logic [2:0] c;
    logic signed [31:0] lhs;
    logic signed [31:0] rhs;
    c = 3'h0;
    lhs = 32'(x) <<< QUANT_SHIFT;
    for (int k = 1; k < 8; k++) begin
      rhs = (k - QUANT_MID) * $signed({17'h00000, bmax});
      if (lhs >= rhs) c = 3'(k);
    end
    return c;
  endfunction

  function automatic logic signed [15:0] pulse_level(input logic [2:0] code);
    return sat16(32'(QUANT_LOW) + 32'(code) * 32'(QUANT_STEP));
  endfunction

  function automatic logic signed [15:0] lar_decode(input logic [5:0] code, input int i);
    logic signed [31:0] t;
    t = $signed({26'h0000000, code}) - $signed({26'h0000000, LAR_OFFSET[i]});
    return sat16(t * 32'(LAR_STEP[i]));
  endfunction

  function automatic logic signed [15:0] lar_interp(input logic signed [15:0] p, input logic signed [15:0] c,
                                                     input logic [1:0] seg);
    case (seg)
      2'h0: return add_sat(add_sat(p >>> 1, p >>> 2), c >>> 2);
      2'h1: return add_sat(p >>> 1, c >>> 1);
      2'h2: return add_sat(p >>> 2, add_sat(c >>> 1, c >>> 2));
      default: return c;
    endcase
  endfunction

  // above the knee the ratio is compressed so the coefficient stays inside the unit range
  function automatic logic signed [15:0] lar_to_rc(input logic signed [15:0] lar);
    logic signed [31:0] a;
    logic signed [31:0] m;
    a = (lar < 0) ? -32'(lar) : 32'(lar);
    m = (a < 32'(RC_KNEE)) ? a : 32'(RC_KNEE) + ((a - 32'(RC_KNEE)) >>> 2);
    return sat16((lar < 0) ? -m : m);
  endfunction
endpackage

// >>> rtl/rpeasd_fifo.sv
/*
  synchronous fifo with valid/ready on both sides.
  assumes one clock; full drops in_ready, empty drops out_valid.
*/
`timescale 1ns/1ps
module rpeasd_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
  logic [AW:0] cnt_reg, cnt_next;
  logic push, pop;

  assign in_ready = (cnt_reg != (AW+1)'(DEPTH));
  assign out_valid = (cnt_reg != '0);
  assign out_data = mem[rptr_reg];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  always_comb begin
    wptr_next = push ? ((wptr_reg == AW'(DEPTH - 1)) ? '0 : wptr_reg + 1'b1) : wptr_reg;
    rptr_next = pop ? ((rptr_reg == AW'(DEPTH - 1)) ? '0 : rptr_reg + 1'b1) : rptr_reg;
    cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wptr_reg <= '0;
      rptr_reg <= '0;
      cnt_reg <= '0;
    end else begin
      wptr_reg <= wptr_next;
      rptr_reg <= rptr_next;
      cnt_reg <= cnt_next;
    end
  end

  always_ff @(posedge clk) begin
    if (push) mem[wptr_reg] <= in_data;
  end
endmodule

// >>> rtl/rpeasd_lattice.sv
/*
  eight-stage lattice synthesis filter, one sample per step pulse.
  assumes coefficients held stable during the step cycle; result registered.
*/
`timescale 1ns/1ps
module rpeasd_lattice
  import rpeasd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic step,
  input wire logic signed [15:0] d_in,
  input wire logic signed [LAR_NUM-1:0][15:0] rc,
  output logic signed [15:0] s_out,
  output logic s_valid
);
  logic signed [15:0] v_reg [LAR_NUM];
  logic signed [15:0] v_next [LAR_NUM];
  logic signed [15:0] sr [LAR_NUM+1];
  logic signed [15:0] vn [LAR_NUM+1];
  logic signed [15:0] s_out_next;

  assign sr[0] = d_in;
  for (genvar i = 1; i <= LAR_NUM; i++) begin : g_stage
    assign sr[i] = sub_sat(sr[i-1], mult_r(rc[LAR_NUM-i], v_reg[LAR_NUM-i])); // RULE_10
    assign vn[LAR_NUM+1-i] = add_sat(v_reg[LAR_NUM-i], mult_r(rc[LAR_NUM-i], sr[i])); // RULE_10
  end
  assign vn[0] = sr[LAR_NUM]; // RULE_10

  always_comb begin
    s_out_next = step ? sr[LAR_NUM] : s_out;
    for (int j = 0; j < LAR_NUM; j++) begin
      v_next[j] = step ? vn[j] : v_reg[j];
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int j = 0; j < LAR_NUM; j++) v_reg[j] <= STATE_RST; // RULE_16
      s_out <= STATE_RST;
      s_valid <= 1'b0;
    end else begin
      v_reg <= v_next;
      s_out <= s_out_next;
      s_valid <= step;
    end
  end
endmodule

// >>> rtl/rpeasd_codec.sv
/*
  pulse sequence quantizer and frame synthesis decoder.
  assumes upstream logic on clk delivering residual samples and frame parameter words,
  and downstream logic draining speech samples through the output fifo.
*/
`timescale 1ns/1ps
// Contract
// [RULE_01] take the largest magnitude of each 13-sample sequence as a 6-bit code
// [RULE_02] log code map: width 32 up to 511, doubling every eight; decode to upper bound
// [RULE_03] normalize every pulse sample by the decoded maximum, not the raw one
// [RULE_04] quantize normalized samples into eight uniform 8192-wide intervals, codes 0..7
// [RULE_05] pulse code to level, times decoded maximum, gives the decoded pulse
// [RULE_06] spread 13 pulses three apart from the grid offset, zeros elsewhere
// [RULE_07] decode pulses, long term synthesis, short term synthesis, de-emphasis, in order
// [RULE_08] long residual feeds long term synthesis; its output feeds the lattice
// [RULE_09] rebuild lattice coefficients by ratio decoding, interpolation and transformation
// [RULE_10] eight-stage lattice with the stated forward and state recursions
// [RULE_11] first-order recursive de-emphasis with feedback 28180 over 2^15
// [RULE_12] the grid phase code is a two-bit field
// [RULE_13] 40-sample subsegments; residual plus gain times history delayed by lag
// [RULE_14] two-bit gain code selects 0.10, 0.35, 0.65 or 1.00
// [RULE_15] interpolate coefficient sets in early frame ranges, then current set alone
// [RULE_16] valid/ready word transfers; filter states clear on reset
// [RULE_17] saturating 16-bit fixed point with 2^15 scaling, bit exact
module rpeasd_codec
  import rpeasd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic res_valid,
  output logic res_ready,
  input wire logic signed [15:0] res_data,
  output logic code_valid,
  input wire logic code_ready,
  output logic [5:0] code_data,
  output logic code_is_max,
  input wire logic par_valid,
  output logic par_ready,
  input wire logic [15:0] par_data,
  output logic spk_valid,
  input wire logic spk_ready,
  output logic signed [15:0] spk_data
);
  typedef enum logic [0:0] {ENC_FILL = 1'b0, ENC_SEND = 1'b1} rpeasd_enc_t;
  typedef enum logic [1:0] {DEC_LAR = 2'b00, DEC_PAR = 2'b01, DEC_RUN = 2'b10, DEC_WAIT = 2'b11} rpeasd_dec_t;

  // quantizer side
  rpeasd_enc_t enc_state_reg, enc_state_next;
  logic [3:0] eidx_reg, eidx_next, oidx_reg, oidx_next;
  logic [14:0] absmax_reg, absmax_next, cur_abs, absmax_cand;
  logic [5:0] bmax_code_reg, bmax_code_next, code_data_reg, code_data_next;
  logic code_is_max_reg, code_is_max_next;
  logic signed [15:0] enc_samp [PULSE_NUM];

  assign res_ready = (enc_state_reg == ENC_FILL); // RULE_16
  assign code_valid = (enc_state_reg == ENC_SEND); // RULE_16
  assign code_data = code_data_reg;
  assign code_is_max = code_is_max_reg;
  assign cur_abs = abs15(res_data);
  assign absmax_cand = (cur_abs > absmax_reg) ? cur_abs : absmax_reg; // RULE_01

  always_comb begin
    enc_state_next = enc_state_reg;
    eidx_next = eidx_reg;
    oidx_next = oidx_reg;
    absmax_next = absmax_reg;
    bmax_code_next = bmax_code_reg;
    code_data_next = code_data_reg;
    code_is_max_next = code_is_max_reg;
    case (enc_state_reg)
      ENC_FILL: begin
        if (res_valid) begin
          eidx_next = eidx_reg + 4'h1;
          absmax_next = absmax_cand;
          if (eidx_reg == 4'(PULSE_NUM - 1)) begin
            enc_state_next = ENC_SEND;
            eidx_next = 4'h0;
            oidx_next = 4'h0;
            bmax_code_next = bmax_encode(absmax_cand); // RULE_01 RULE_02
            code_data_next = bmax_encode(absmax_cand); // RULE_02
            code_is_max_next = 1'b1;
          end
        end
      end
      ENC_SEND: begin
        if (code_ready) begin
          code_is_max_next = 1'b0;
          if (oidx_reg == 4'(PULSE_NUM)) begin
            enc_state_next = ENC_FILL;
            absmax_next = 15'h0000;
          end else begin
            // dividing by the decoded maximum keeps encoder and decoder scaling identical
            code_data_next = {3'h0, quant_code(enc_samp[oidx_reg], bmax_decode(bmax_code_reg))}; // RULE_03 RULE_04
            oidx_next = oidx_reg + 4'h1;
          end
        end
      end
      default: enc_state_next = ENC_FILL;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enc_state_reg <= ENC_FILL;
      eidx_reg <= 4'h0;
      oidx_reg <= 4'h0;
      absmax_reg <= 15'h0000;
      bmax_code_reg <= 6'h00;
      code_data_reg <= 6'h00;
      code_is_max_reg <= 1'b0;
    end else begin
      enc_state_reg <= enc_state_next;
      eidx_reg <= eidx_next;
      oidx_reg <= oidx_next;
      absmax_reg <= absmax_next;
      bmax_code_reg <= bmax_code_next;
      code_data_reg <= code_data_next;
      code_is_max_reg <= code_is_max_next;
    end
  end

  always_ff @(posedge clk) begin
    if (res_valid && res_ready) enc_samp[eidx_reg] <= res_data;
  end

  // decoder side
  rpeasd_dec_t dec_state_reg, dec_state_next;
  logic [4:0] widx_reg, widx_next;
  logic [1:0] sub_reg, sub_next;
  logic [5:0] k_reg, k_next;
  logic [3:0] pidx_reg, pidx_next, pidx_sel;
  logic [6:0] lag_reg, lag_next;
  logic [1:0] gain_reg, gain_next;
  logic [1:0] grid_phase_code_reg, grid_phase_code_next;
  logic [5:0] rx_bmax_reg, rx_bmax_next;
  logic [6:0] wptr_reg, wptr_next;
  logic signed [15:0] deemphasis_output_reg, deemphasis_output_next;
  logic [2:0] pulse_level_code [PULSE_NUM];
  logic signed [15:0] lar_prev [LAR_NUM];
  logic signed [15:0] lar_cur [LAR_NUM];
  logic signed [15:0] hist [HIST_DEPTH];
  logic par_take, pulse_hit, lat_step, lat_valid, fifo_in_ready;
  logic [5:0] pulse_pos;
  logic [1:0] seg;
  logic signed [15:0] pulse_val, rebuilt_long_residual, rebuilt_short_residual, hist_rd, lat_out;
  logic signed [LAR_NUM-1:0][15:0] rc;

  assign par_ready = (dec_state_reg == DEC_LAR) || (dec_state_reg == DEC_PAR); // RULE_16
  assign par_take = par_valid && par_ready;
  assign pidx_sel = (pidx_reg < 4'(PULSE_NUM)) ? pidx_reg : 4'h0;
  assign pulse_pos = 6'(grid_phase_code_reg) + 6'(GRID_STEP) * 6'(pidx_reg); // RULE_06
  assign pulse_hit = (k_reg == pulse_pos) && (pidx_reg < 4'(PULSE_NUM)); // RULE_06
  assign pulse_val = mult_r(pulse_level(pulse_level_code[pidx_sel]), $signed({1'b0, bmax_decode(rx_bmax_reg)})); // RULE_05
  assign rebuilt_long_residual = pulse_hit ? pulse_val : STATE_RST; // RULE_06 RULE_07
  assign hist_rd = hist[wptr_reg - lag_reg]; // RULE_13
  assign rebuilt_short_residual = add_sat(rebuilt_long_residual, mult_r(GAIN_LEVEL[gain_reg], hist_rd)); // RULE_08 RULE_13 RULE_14 RULE_17
  assign lat_step = (dec_state_reg == DEC_RUN) && fifo_in_ready; // RULE_16
  // only the first subsegment of a frame spans the interpolated ranges
  assign seg = (sub_reg != 2'h0) ? 2'h3 : (k_reg < 6'(INTERP_END0)) ? 2'h0 :
               (k_reg < 6'(INTERP_END1)) ? 2'h1 : (k_reg < 6'(SUB_LEN)) ? 2'h2 : 2'h3; // RULE_15

  for (genvar i = 0; i < LAR_NUM; i++) begin : g_coef
    assign rc[i] = lar_to_rc(lar_interp(lar_prev[i], lar_cur[i], seg)); // RULE_09 RULE_15
  end

  always_comb begin
    dec_state_next = dec_state_reg;
    widx_next = widx_reg;
    sub_next = sub_reg;
    k_next = k_reg;
    pidx_next = pidx_reg;
    lag_next = lag_reg;
    gain_next = gain_reg;
    grid_phase_code_next = grid_phase_code_reg;
    rx_bmax_next = rx_bmax_reg;
    wptr_next = wptr_reg;
    deemphasis_output_next = deemphasis_output_reg;
    case (dec_state_reg)
      DEC_LAR: begin
        if (par_take) begin
          widx_next = widx_reg + 5'h01;
          if (widx_reg == 5'(LAR_NUM - 1)) begin
            dec_state_next = DEC_PAR;
            widx_next = 5'h00;
          end
        end
      end
      DEC_PAR: begin
        if (par_take) begin
          widx_next = widx_reg + 5'h01;
          case (widx_reg)
            5'h00: lag_next = par_data[6:0];
            5'h01: gain_next = par_data[1:0]; // RULE_14
            5'h02: grid_phase_code_next = par_data[1:0]; // RULE_12
            5'h03: rx_bmax_next = par_data[5:0];
            default: ;
          endcase
          if (widx_reg == 5'(PAR_WORDS - 1)) begin
            dec_state_next = DEC_RUN;
            widx_next = 5'h00;
            k_next = 6'h00;
            pidx_next = 4'h0;
          end
        end
      end
      DEC_RUN: begin
        // stalls here while the output fifo is full, so no sample is ever dropped
        if (lat_step) begin
          dec_state_next = DEC_WAIT;
          k_next = k_reg + 6'h01;
          wptr_next = wptr_reg + 7'h01;
          if (pulse_hit) pidx_next = pidx_reg + 4'h1;
        end
      end
      DEC_WAIT: begin
        if (lat_valid) begin
          deemphasis_output_next = add_sat(lat_out, mult_r(BETA, deemphasis_output_reg)); // RULE_11 RULE_07
          if (k_reg == 6'(SUB_LEN)) begin
            k_next = 6'h00;
            widx_next = 5'h00;
            if (sub_reg == 2'(SUB_NUM - 1)) begin
              dec_state_next = DEC_LAR;
              sub_next = 2'h0;
            end else begin
              dec_state_next = DEC_PAR;
              sub_next = sub_reg + 2'h1;
            end
          end else begin
            dec_state_next = DEC_RUN;
          end
        end
      end
      default: dec_state_next = DEC_LAR;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      dec_state_reg <= DEC_LAR;
      widx_reg <= 5'h00;
      sub_reg <= 2'h0;
      k_reg <= 6'h00;
      pidx_reg <= 4'h0;
      lag_reg <= 7'h00;
      gain_reg <= 2'h0;
      grid_phase_code_reg <= 2'h0;
      rx_bmax_reg <= 6'h00;
      wptr_reg <= 7'h00;
      deemphasis_output_reg <= STATE_RST; // RULE_16
    end else begin
      dec_state_reg <= dec_state_next;
      widx_reg <= widx_next;
      sub_reg <= sub_next;
      k_reg <= k_next;
      pidx_reg <= pidx_next;
      lag_reg <= lag_next;
      gain_reg <= gain_next;
      grid_phase_code_reg <= grid_phase_code_next;
      rx_bmax_reg <= rx_bmax_next;
      wptr_reg <= wptr_next;
      deemphasis_output_reg <= deemphasis_output_next;
    end
  end

  // coefficient sets and history are state too, so reset clears them
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int j = 0; j < LAR_NUM; j++) begin
        lar_prev[j] <= STATE_RST; // RULE_16
        lar_cur[j] <= STATE_RST;
      end
      for (int j = 0; j < HIST_DEPTH; j++) hist[j] <= STATE_RST; // RULE_16
    end else begin
      if (par_take && dec_state_reg == DEC_LAR) begin
        if (widx_reg == 5'h00) lar_prev <= lar_cur; // RULE_15
        lar_cur[widx_reg[2:0]] <= lar_decode(par_data[5:0], int'(widx_reg[2:0])); // RULE_09
      end
      if (lat_step) hist[wptr_reg] <= rebuilt_short_residual; // RULE_13
    end
  end

  always_ff @(posedge clk) begin
    if (par_take && dec_state_reg == DEC_PAR && widx_reg >= 5'(PAR_PULSE0))
      pulse_level_code[4'(widx_reg - 5'(PAR_PULSE0))] <= par_data[2:0];
  end

  rpeasd_lattice u_lattice (
    .clk(clk),
    .sys_rst(sys_rst),
    .step(lat_step),
    .d_in(rebuilt_short_residual), // RULE_08
    .rc(rc),
    .s_out(lat_out),
    .s_valid(lat_valid)
  );

  rpeasd_fifo #(
    .WIDTH(SAMPLE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(clk),
    .sys_rst(sys_rst),
    .in_valid(lat_valid),
    .in_ready(fifo_in_ready),
    .in_data(deemphasis_output_next),
    .out_valid(spk_valid),
    .out_ready(spk_ready),
    .out_data(spk_data)
  );
endmodule

// >>> tb/rpeasd_codec_asserts.sv
/* port assertions for the codec top.
   assumes a bind onto rpeasd_codec, one clock, sync active-high reset. */
`timescale 1ns/1ps
module rpeasd_codec_asserts (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic res_valid,
  input wire logic res_ready,
  input wire logic signed [15:0] res_data,
  input wire logic code_valid,
  input wire logic code_ready,
  input wire logic [5:0] code_data,
  input wire logic code_is_max,
  input wire logic par_valid,
  input wire logic par_ready,
  input wire logic [15:0] par_data,
  input wire logic spk_valid,
  input wire logic spk_ready,
  input wire logic signed [15:0] spk_data
);
  // pulse words accepted since the last max word
  logic [3:0] cnt_reg;
  logic [3:0] cnt_next;
  always_comb begin
    cnt_next = cnt_reg;
    if (code_valid && code_ready) begin
      cnt_next = code_is_max ? 4'h0 : cnt_reg + 4'h1;
    end
  end
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      cnt_reg <= 4'h0;
    end else begin
      cnt_reg <= cnt_next;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence max_taken;
    code_valid && code_ready && code_is_max;
  endsequence
  sequence last_taken;
    code_valid && code_ready && !code_is_max && cnt_reg == 4'hC;
  endsequence
  a_max_leads: assert property ($rose(code_valid) |-> code_is_max)
    else $error("code burst did not open with the max word");
  a_max_then_pulse: assert property (max_taken |=> code_valid && !code_is_max)
    else $error("no pulse word after the max word");
  a_pulse_width: assert property (code_valid && !code_is_max |-> code_data[5:3] == 3'h0)
    else $error("pulse code wider than three bits");
  a_code_held: assert property (code_valid && !code_ready |=> code_valid && $stable(code_data))
    else $error("code word changed before acceptance");
  a_fill_blocked: assert property (res_ready |-> !code_valid && !code_is_max)
    else $error("samples taken while codes pending");
  a_word_count: assert property ($fell(code_valid) |-> cnt_reg == 4'hD)
    else $error("burst did not carry thirteen pulse words");
  a_fill_return: assert property (last_taken |=> res_ready && !code_valid)
    else $error("collection did not resume after last word");
  a_spk_held: assert property (spk_valid && !spk_ready |=> spk_valid && $stable(spk_data))
    else $error("speech word changed before acceptance");
  a_par_pause: assert property ($fell(par_ready) |-> !par_ready [*8])
    else $error("parameter intake reopened too early");
endmodule

// >>> tb/rpeasd_partner.sv
/* frame parameter source and speech consumer.
   assumes the bench seeds the random generator and raises go once. */
`timescale 1ns/1ps
module rpeasd_partner (
  input wire logic clk,
  input wire logic go,
  output logic par_valid,
  input wire logic par_ready,
  output logic [15:0] par_data,
  output logic spk_ready
);
  logic [15:0] words [76];
  initial begin
    par_valid = 1'b0;
    par_data = 16'h0000;
    for (int i = 0; i < 8; i++) words[i] = 16'h0020;
    for (int s = 0; s < 4; s++) begin
      words[8 + s * 17] = 16'h0028;
      words[9 + s * 17] = 16'(s);
      words[10 + s * 17] = 16'(s);
      words[11 + s * 17] = 16'h003F;
      for (int p = 0; p < 13; p++) words[12 + s * 17 + p] = 16'h0007;
    end
    wait (go);
    for (int i = 0; i < 76; i++) begin
      @(negedge clk);
      par_valid = 1'b1;
      par_data = words[i];
      while (!par_ready) @(negedge clk);
      @(posedge clk);
    end
    @(negedge clk);
    par_valid = 1'b0;
    // released bus shows no stale word
    par_data = ~par_data;
  end
  // slow consumer so the output fifo fills and the decoder stalls
  initial spk_ready = 1'b0;
  always @(negedge clk) spk_ready <= ($urandom_range(3) == 0);
endmodule

// >>> tb/tb_top.sv
/* self-checking bench for the codec top.
   assumes partner model and checker files compiled first. */
`timescale 1ns/1ps
module tb_top;
  logic clk, sys_rst, res_valid, res_ready, code_valid, code_ready, code_is_max;
  logic par_valid, par_ready, spk_valid, spk_ready, go;
  logic signed [15:0] res_data, spk_data;
  logic [15:0] par_data;
  logic [5:0] code_data;
  logic [15:0] code_q[$], spk_q[$];
  int error_cnt = 0, checks_done = 0, cycles = 0, spk_cnt = 0;
  int maxes[10] = '{31, 32, 255, 256, 511, 512, 2047, 2048, 32767, -32768};
  int gn[4] = '{3277, 11469, 21299, 32767};
  rpeasd_codec dut_u (.clk(clk), .sys_rst(sys_rst), .res_valid(res_valid), .res_ready(res_ready),
    .res_data(res_data), .code_valid(code_valid), .code_ready(code_ready), .code_data(code_data),
    .code_is_max(code_is_max), .par_valid(par_valid), .par_ready(par_ready), .par_data(par_data),
    .spk_valid(spk_valid), .spk_ready(spk_ready), .spk_data(spk_data));
  rpeasd_partner partner_u (.clk(clk), .go(go), .par_valid(par_valid), .par_ready(par_ready),
    .par_data(par_data), .spk_ready(spk_ready));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
    end
  endtask
  task automatic test_done();
    $display("mismatches %0d, comparisons %0d", error_cnt, checks_done);
    if (error_cnt == 0 && checks_done > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  function automatic int mr(input int a, input int b);
    return (a * b + 16384) >>> 15;
  endfunction
  // one 13-sample sequence whose largest magnitude is m; expectations queued first
  task automatic send_seq(input int m);
    int xs[13];
    int am, c, e, g, w, xm, q, pos;
    am = (m < 0) ? -m : m;
    if (am > 32767) am = 32767;
    pos = $urandom_range(12);
    for (int i = 0; i < 13; i++) xs[i] = (i == pos) ? m : int'($urandom_range(2 * am)) - am;
    e = $clog2(am + 1) - 1;
    c = (am < 256) ? am >> 5 : (e - 7) * 8 + ((am >> (e - 3)) & 7);
    g = c >> 3;
    w = (g < 2) ? 32 : 32 << (g - 1);
    xm = ((g < 2) ? c * 32 : (256 << (g - 1)) + (c & 7) * w) + w - 1;
    code_q.push_back(16'h0100 | 16'(c));
    for (int i = 0; i < 13; i++) begin
      q = 0;
      for (int k = 1; k < 8; k++) if (4 * xs[i] >= (k - 4) * xm) q = k;
      code_q.push_back(16'(q));
    end
    for (int i = 0; i < 13; i++) begin
      @(negedge clk);
      if ($urandom_range(3) == 0) begin
        res_valid = 1'b0;
        res_data = ~res_data;
        @(negedge clk);
      end
      res_valid = 1'b1;
      res_data = 16'(xs[i]);
      while (!res_ready) @(negedge clk);
      @(posedge clk);
    end
  endtask
  always @(negedge clk) code_ready <= ($urandom_range(3) != 0);
  always @(posedge clk) begin
    if (!sys_rst && code_valid && code_ready) begin
      if (code_q.size() == 0) check({7'h00, code_is_max, 2'h0, code_data}, 16'hFFFF);
      else check({7'h00, code_is_max, 2'h0, code_data}, code_q.pop_front());
    end
    if (!sys_rst && spk_valid && spk_ready) begin
      spk_cnt++;
      if (spk_q.size() > 0) check(spk_data, spk_q.pop_front());
    end
    cycles++;
    if (cycles == 30000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    int lvl, prev, x, j;
    int d[160];
    sys_rst = 1'b1;
    res_valid = 1'b0;
    res_data = 16'h0000;
    go = 1'b0;
    code_ready = 1'b1;
    void'($urandom(93207));
    repeat (6) @(negedge clk);
    sys_rst = 1'b0;
    for (int i = 0; i < 10; i++) send_seq(maxes[i]);
    for (int i = 0; i < 6; i++) send_seq(int'($urandom_range(65535)) - 32768);
    @(negedge clk);
    res_valid = 1'b0;
    res_data = ~res_data;
    // zero coefficients pass the lattice through; subsegment s has gain code s, grid s, lag 40
    lvl = mr(-28672 + 7 * 8192, 32767);
    prev = 0;
    for (int k = 0; k < 160; k++) begin
      j = k % 40 - k / 40;
      x = (j >= 0 && j % 3 == 0 && j < 39) ? lvl : 0;
      d[k] = x + ((k < 40) ? 0 : mr(gn[k / 40], d[k - 40]));
      if (d[k] > 32767) d[k] = 32767;
      prev = d[k] + mr(28180, prev);
      if (prev > 32767) prev = 32767;
      spk_q.push_back(16'(prev));
    end
    go = 1'b1;
    while (spk_cnt < 160 || code_q.size() > 0) @(negedge clk);
    repeat (200) @(negedge clk);
    check(16'(spk_cnt), 16'h00A0);
    test_done();
  end
endmodule
bind rpeasd_codec rpeasd_codec_asserts chk_u (.clk(clk), .sys_rst(sys_rst), .res_valid(res_valid),
  .res_ready(res_ready), .res_data(res_data), .code_valid(code_valid), .code_ready(code_ready),
  .code_data(code_data), .code_is_max(code_is_max), .par_valid(par_valid), .par_ready(par_ready),
  .par_data(par_data), .spk_valid(spk_valid), .spk_ready(spk_ready), .spk_data(spk_data));
